//--- pkg/sdm_defines.svh
// Constants of the surround-disturb self-test sequencer.
// Assumes one clock domain and an AXI4-Lite register port.
`ifndef SDM_DEFINES_SVH
`define SDM_DEFINES_SVH

// Geometry: fast column, slow row, bank
`define SDM_COL_W        3
`define SDM_ROW_W        3
`define SDM_BANK_W       1
`define SDM_ADDR_W       7
`define SDM_DATA_W       8
`define SDM_HAS_BANK     1'b1
`define SDM_SLOTS_BANK   4'h8
`define SDM_SLOTS_NOBANK 4'h7

// Read repeat end count: two reads
`define SDM_REP_END      1'b1
`define SDM_IB_LAST      2'h3
`define SDM_WSTEP_LAST   3'h7

`define SDM_ZERO         8'h00
`define SDM_ONES         8'hff
`define SDM_ODD_EN       8'haa
`define SDM_EVEN_EN      8'h55

// Register map, byte addresses
`define SDM_AXI_AW       8
`define SDM_OFF_CTRL     8'h00
`define SDM_OFF_STATUS   8'h04
`define SDM_OFF_IRQ_STAT 8'h08
`define SDM_OFF_IRQ_MASK 8'h0c
`define SDM_OFF_FAIL_ADR 8'h10

`define SDM_CTRL_START   0
`define SDM_CTRL_EXT     1
`define SDM_ST_BUSY      0
`define SDM_ST_FAIL      1
`define SDM_ST_EXT       2
`define SDM_IRQ_DONE     0
`define SDM_IRQ_FAIL     1

`define SDM_RESP_OKAY    2'b00
`define SDM_RESP_SLVERR  2'b10

`endif

//--- pkg/sdm_pkg.sv
// Types of the surround-disturb self-test sequencer.
// Assumes sdm_defines.svh on the include path.
`include "sdm_defines.svh"

package sdm_pkg;

    typedef enum logic [1:0] {
        SDM_OP_NOP,
        SDM_OP_WRITE,
        SDM_OP_READ
    } sdm_op_t;

    typedef enum logic [3:0] {
        SDM_S_IDLE,
        SDM_S_BG,
        SDM_S_OFFSET,
        SDM_S_AW1,
        SDM_S_RH1,
        SDM_S_AW2,
        SDM_S_RH2,
        SDM_S_MOVE,
        SDM_S_BANK,
        SDM_S_WE,
        SDM_S_LK_FILL,
        SDM_S_LK_TGT,
        SDM_S_LK_RD1,
        SDM_S_LK_RD2,
        SDM_S_DONE
    } sdm_state_t;

    typedef struct packed {
        sdm_op_t                 op;
        logic                    gwe;
        logic [`SDM_DATA_W-1:0]  bwe;
        logic [`SDM_DATA_W-1:0]  data;
    } sdm_step_t;

endpackage

//--- rtl/sdm_addr_field.sv
// One address field counter: clear, load, increment, decrement.
// Assumes the caller never raises inc and dec together.
`timescale 1ns/1ps

module sdm_addr_field #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // Control
    input  wire logic         clr,
    input  wire logic         ld,
    input  wire logic [W-1:0] ld_val,
    input  wire logic         inc,
    input  wire logic         dec,
    // State
    output logic      [W-1:0] val_q,
    output logic      [W-1:0] nxt,
    output logic              at_max,
    output logic              carry
);

    assign at_max = &val_q;
    assign carry  = inc & at_max;
    assign nxt    = clr ? '0 :
                    ld  ? ld_val :
                    inc ? W'(val_q + 1'b1) :
                    dec ? W'(val_q - 1'b1) : val_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            val_q <= '0;
        end else begin
            val_q <= nxt;
        end
    end

endmodule

//--- rtl/sdm_seq.sv
// Surround-disturb self-test sequencer, AXI4-Lite registers.
// Assumes a synchronous SRAM on the same clock, read data one cycle
// after the sampled request.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

// Summary of operation
// - Home reads repeat twice.
// - Data registers start zero.
// - Fast carry feeds slow field.
// - Background writes every cell.
// - Offset decrements away row, column.
// - Away write one, inverse, slow step.
// - Home read one compares, repeats.
// - Away write two, inverse, fast step.
// - Inner loop inverts address, data, both.
// - Move home, copy to away.
// - Next bank, copy to away.
// - Rerun once with data inverted.
// - Eight slots with bank, else seven.
// - Read-modify-write as read, write.
// - Write, blocked write, read back.
// - Opposite odd/even, bit/global enables.
// - Lone target value in column, both.
// - Target read twice back to back.
module sdm_seq (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // AXI4-Lite write address and data
    input  wire logic [`SDM_AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [`SDM_AXI_AW-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Interrupt
    output logic                        irq,
    // Memory under test
    output logic                        mem_ce,
    output logic                        mem_we,
    output logic [`SDM_DATA_W-1:0]      mem_bwe,
    output logic [`SDM_ADDR_W-1:0]      mem_addr,
    output logic [`SDM_DATA_W-1:0]      mem_wdata,
    input  wire logic [`SDM_DATA_W-1:0] mem_rdata
);
    import sdm_pkg::*;

    // Write-enable stimulus at address zero
    function automatic sdm_step_t we_step(input logic [2:0] idx);
        sdm_step_t s;
        s = '{SDM_OP_NOP, 1'b0, `SDM_ZERO, `SDM_ZERO};
        case (idx)
            3'h0: s = '{SDM_OP_WRITE, 1'b1, `SDM_ONES, `SDM_ZERO};
            3'h1: s = '{SDM_OP_WRITE, 1'b0, `SDM_ZERO, `SDM_ONES};
            3'h2: s = '{SDM_OP_READ, 1'b0, `SDM_ZERO, `SDM_ZERO};
            3'h3: s = '{SDM_OP_WRITE, 1'b1, `SDM_EVEN_EN, `SDM_ONES};
            3'h4: s = '{SDM_OP_READ, 1'b0, `SDM_ZERO, `SDM_EVEN_EN};
            3'h5: s = '{SDM_OP_WRITE, 1'b1, `SDM_ODD_EN, `SDM_ONES};
            3'h6: s = '{SDM_OP_WRITE, 1'b0, `SDM_ONES, `SDM_ZERO};
            3'h7: s = '{SDM_OP_READ, 1'b0, `SDM_ZERO, `SDM_ONES};
            default: s = '{SDM_OP_NOP, 1'b0, `SDM_ZERO, `SDM_ZERO};
        endcase
        return s;
    endfunction

    // Register bus state
    logic                   aw_have_q, w_have_q;
    logic [`SDM_AXI_AW-1:0] awaddr_q;
    logic [31:0]            wdata_q;
    logic [3:0]             wstrb_q;
    logic                   ext_q;
    logic [1:0]             irq_stat_q, irq_mask_q;
    logic [`SDM_ADDR_W-1:0] fail_adr_q;
    logic                   fail_q;

    // Sequencer state
    sdm_state_t             st_q, st_d;
    logic                   rep_q, rep_d;
    logic [1:0]             ib_q, ib_d;
    logic                   outer_q, outer_d;
    logic [2:0]             wstep_q, wstep_d;
    logic                   lpol_q, lpol_d;

    // Compare pipeline
    logic                   cmp1_q, cmp2_q;
    logic [`SDM_DATA_W-1:0] exp1_q, exp2_q;
    logic [`SDM_ADDR_W-1:0] adr2_q;

    // Per-state controls
    sdm_op_t                m_op;
    logic                   m_away, m_gwe, done_ev;
    logic [`SDM_DATA_W-1:0] m_bwe, m_wdata, m_exp;
    logic                   hc_inc, hr_inc, hb_inc;
    logic                   a_ld, ac_inc, ac_dec, ar_inc, ar_dec;
    sdm_step_t              wst;

    // Address fields
    logic [`SDM_COL_W-1:0]  hcol, hcol_n, acol;
    logic [`SDM_ROW_W-1:0]  hrow, hrow_n, arow;
    logic [`SDM_BANK_W-1:0] hbank;
    logic                   hcol_max, hrow_max, hbank_max, hcol_cy;

    // Bus decode
    wire aw_hs     = s_axi_awvalid & s_axi_awready;
    wire w_hs      = s_axi_wvalid & s_axi_wready;
    wire wr_commit = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire ar_hs     = s_axi_arvalid & s_axi_arready;
    wire wr_lane0  = wr_commit & wstrb_q[0];
    wire wr_ctrl   = wr_lane0 & (awaddr_q == `SDM_OFF_CTRL);
    wire wr_istat  = wr_lane0 & (awaddr_q == `SDM_OFF_IRQ_STAT);
    wire wr_imask  = wr_lane0 & (awaddr_q == `SDM_OFF_IRQ_MASK);
    wire wr_hit    = (awaddr_q == `SDM_OFF_CTRL) |
                     (awaddr_q == `SDM_OFF_STATUS) |
                     (awaddr_q == `SDM_OFF_IRQ_STAT) |
                     (awaddr_q == `SDM_OFF_IRQ_MASK) |
                     (awaddr_q == `SDM_OFF_FAIL_ADR);
    wire idle      = (st_q == SDM_S_IDLE);
    wire start     = wr_ctrl & wdata_q[`SDM_CTRL_START] & idle;
    wire busy      = ~idle;
    wire [3:0] slots = `SDM_HAS_BANK ? `SDM_SLOTS_BANK
                                     : `SDM_SLOTS_NOBANK;

    wire rd_ctrl   = (s_axi_araddr == `SDM_OFF_CTRL);
    wire rd_stat   = (s_axi_araddr == `SDM_OFF_STATUS);
    wire rd_istat  = (s_axi_araddr == `SDM_OFF_IRQ_STAT);
    wire rd_imask  = (s_axi_araddr == `SDM_OFF_IRQ_MASK);
    wire rd_fadr   = (s_axi_araddr == `SDM_OFF_FAIL_ADR);
    wire rd_hit    = rd_ctrl | rd_stat | rd_istat | rd_imask | rd_fadr;
    wire [31:0] rd_val =
        rd_ctrl  ? {30'h0, ext_q, 1'b0} :
        rd_stat  ? {24'h0, slots, 1'b0, ext_q, fail_q, busy} :
        rd_istat ? {30'h0, irq_stat_q} :
        rd_imask ? {30'h0, irq_mask_q} :
        rd_fadr  ? {25'h0, fail_adr_q} : 32'h0;

    // Data register and address choices
    wire [`SDM_DATA_W-1:0] dreg = outer_q ? `SDM_ONES : `SDM_ZERO;
    wire [`SDM_DATA_W-1:0] away_d = ib_q[1] ? dreg : ~dreg;
    wire [`SDM_DATA_W-1:0] lk_fill = lpol_q ? `SDM_ONES : `SDM_ZERO;
    wire home_end = hcol_max & hrow_max;
    wire [`SDM_ADDR_W-1:0] home_adr = {hbank, hrow, hcol};
    wire [`SDM_ADDR_W-1:0] away_adr = {hbank, arow, acol};
    wire mismatch = cmp2_q & (mem_rdata != exp2_q);
    wire [1:0] irq_ev = {mismatch, done_ev};
    assign wst = we_step(wstep_q);

    // Home register, fast carry into slow
    sdm_addr_field #(.W(`SDM_COL_W)) u_hcol (
        .clock(clock), .rst_n(rst_n), .clr(start), .ld(1'b0),
        .ld_val('0), .inc(hc_inc), .dec(1'b0), .val_q(hcol),
        .nxt(hcol_n), .at_max(hcol_max), .carry(hcol_cy));
    sdm_addr_field #(.W(`SDM_ROW_W)) u_hrow (
        .clock(clock), .rst_n(rst_n), .clr(start), .ld(1'b0),
        .ld_val('0), .inc(hcol_cy | hr_inc), .dec(1'b0), .val_q(hrow),
        .nxt(hrow_n), .at_max(hrow_max), .carry());
    sdm_addr_field #(.W(`SDM_BANK_W)) u_hbank (
        .clock(clock), .rst_n(rst_n), .clr(start), .ld(1'b0),
        .ld_val('0), .inc(hb_inc), .dec(1'b0), .val_q(hbank),
        .nxt(), .at_max(hbank_max), .carry());
    // Away register, loaded from home next
    sdm_addr_field #(.W(`SDM_COL_W)) u_acol (
        .clock(clock), .rst_n(rst_n), .clr(start), .ld(a_ld),
        .ld_val(hcol_n), .inc(ac_inc), .dec(ac_dec), .val_q(acol),
        .nxt(), .at_max(), .carry());
    sdm_addr_field #(.W(`SDM_ROW_W)) u_arow (
        .clock(clock), .rst_n(rst_n), .clr(start), .ld(a_ld),
        .ld_val(hrow_n), .inc(ar_inc), .dec(ar_dec), .val_q(arow),
        .nxt(), .at_max(), .carry());

    // Instruction sequencing
    always_comb begin
        st_d = st_q;
        rep_d = rep_q;
        ib_d = ib_q;
        outer_d = outer_q;
        wstep_d = wstep_q;
        lpol_d = lpol_q;
        m_op = SDM_OP_NOP;
        m_away = 1'b0;
        m_gwe = 1'b0;
        m_bwe = `SDM_ZERO;
        m_wdata = `SDM_ZERO;
        m_exp = dreg;
        {hc_inc, hr_inc, hb_inc} = 3'b000;
        {a_ld, ac_inc, ac_dec, ar_inc, ar_dec} = 5'b00000;
        done_ev = 1'b0;
        case (st_q)
            SDM_S_IDLE: begin
                if (start) begin
                    st_d = SDM_S_BG;
                    rep_d = 1'b0;
                    ib_d = 2'h0;
                    outer_d = 1'b0;
                    wstep_d = 3'h0;
                    lpol_d = 1'b0;
                end
            end
            SDM_S_BG: begin
                m_op = SDM_OP_WRITE;
                m_gwe = 1'b1;
                m_bwe = `SDM_ONES;
                m_wdata = dreg;
                hc_inc = 1'b1;
                if (home_end) begin
                    st_d = SDM_S_OFFSET;
                end
            end
            SDM_S_OFFSET: begin
                {ac_dec, ar_dec} = 2'b11;
                st_d = SDM_S_AW1;
            end
            SDM_S_AW1, SDM_S_AW2: begin
                m_op = SDM_OP_WRITE;
                m_away = 1'b1;
                m_gwe = 1'b1;
                m_bwe = `SDM_ONES;
                m_wdata = away_d;
                if (st_q == SDM_S_AW1) begin
                    {ar_dec, ar_inc} = {ib_q[0], ~ib_q[0]};
                    st_d = SDM_S_RH1;
                end else begin
                    {ac_dec, ac_inc} = {ib_q[0], ~ib_q[0]};
                    st_d = SDM_S_RH2;
                end
            end
            SDM_S_RH1: begin
                m_op = SDM_OP_READ;
                if (rep_q == `SDM_REP_END) begin
                    rep_d = 1'b0;
                    st_d = SDM_S_AW2;
                end else begin
                    rep_d = 1'b1;
                    st_d = SDM_S_AW1;
                end
            end
            SDM_S_RH2: begin
                m_op = SDM_OP_READ;
                if (rep_q != `SDM_REP_END) begin
                    rep_d = 1'b1;
                    st_d = SDM_S_AW2;
                end else if (ib_q == `SDM_IB_LAST) begin
                    rep_d = 1'b0;
                    ib_d = 2'h0;
                    st_d = SDM_S_MOVE;
                end else begin
                    rep_d = 1'b0;
                    ib_d = 2'(ib_q + 1'b1);
                    st_d = SDM_S_AW1;
                end
            end
            SDM_S_MOVE, SDM_S_BANK: begin
                a_ld = 1'b1;
                hc_inc = (st_q == SDM_S_MOVE);
                hb_inc = (st_q == SDM_S_BANK);
                if (st_q == SDM_S_MOVE && !home_end) begin
                    st_d = SDM_S_OFFSET;
                end else if (st_q == SDM_S_MOVE && `SDM_HAS_BANK) begin
                    st_d = SDM_S_BANK;
                end else if (st_q == SDM_S_BANK && !hbank_max) begin
                    st_d = SDM_S_BG;
                end else if (!outer_q) begin
                    outer_d = 1'b1;
                    st_d = SDM_S_BG;
                end else begin
                    st_d = ext_q ? SDM_S_WE : SDM_S_DONE;
                end
            end
            SDM_S_WE: begin
                m_op = wst.op;
                m_gwe = wst.gwe;
                m_bwe = wst.bwe;
                m_wdata = wst.data;
                m_exp = wst.data;
                wstep_d = 3'(wstep_q + 1'b1);
                if (wstep_q == `SDM_WSTEP_LAST) begin
                    st_d = SDM_S_LK_FILL;
                end
            end
            SDM_S_LK_FILL: begin
                m_op = SDM_OP_WRITE;
                m_gwe = 1'b1;
                m_bwe = `SDM_ONES;
                m_wdata = lk_fill;
                hr_inc = 1'b1;
                if (hrow_max) begin
                    st_d = SDM_S_LK_TGT;
                end
            end
            SDM_S_LK_TGT: begin
                m_op = SDM_OP_WRITE;
                m_gwe = 1'b1;
                m_bwe = `SDM_ONES;
                m_wdata = ~lk_fill;
                st_d = SDM_S_LK_RD1;
            end
            SDM_S_LK_RD1: begin
                m_op = SDM_OP_READ;
                m_exp = ~lk_fill;
                st_d = SDM_S_LK_RD2;
            end
            SDM_S_LK_RD2: begin
                m_op = SDM_OP_READ;
                m_exp = ~lk_fill;
                lpol_d = 1'b1;
                st_d = lpol_q ? SDM_S_DONE : SDM_S_LK_FILL;
            end
            SDM_S_DONE: begin
                if (!cmp1_q && !cmp2_q) begin
                    done_ev = 1'b1;
                    st_d = SDM_S_IDLE;
                end
            end
            default: st_d = SDM_S_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= SDM_S_IDLE;
            rep_q <= 1'b0;
            ib_q <= 2'h0;
            outer_q <= 1'b0;
            wstep_q <= 3'h0;
            lpol_q <= 1'b0;
        end else begin
            st_q <= st_d;
            rep_q <= rep_d;
            ib_q <= ib_d;
            outer_q <= outer_d;
            wstep_q <= wstep_d;
            lpol_q <= lpol_d;
        end
    end

    // Memory request register; no read-modify-write at this port
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_ce <= 1'b0;
            mem_we <= 1'b0;
            mem_bwe <= `SDM_ZERO;
            mem_addr <= '0;
            mem_wdata <= `SDM_ZERO;
        end else begin
            mem_ce <= (m_op != SDM_OP_NOP);
            mem_we <= m_gwe;
            mem_bwe <= m_bwe;
            mem_addr <= m_away ? away_adr : home_adr;
            mem_wdata <= m_wdata;
        end
    end

    // Compare two cycles after read issue
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmp1_q <= 1'b0;
            cmp2_q <= 1'b0;
            exp1_q <= `SDM_ZERO;
            exp2_q <= `SDM_ZERO;
            adr2_q <= '0;
        end else begin
            cmp1_q <= (m_op == SDM_OP_READ);
            exp1_q <= m_exp;
            cmp2_q <= cmp1_q;
            exp2_q <= exp1_q;
            adr2_q <= mem_addr;
        end
    end

    // Sticky fail flag and first failing address
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fail_q <= 1'b0;
            fail_adr_q <= '0;
        end else begin
            fail_q <= mismatch | (fail_q & ~start);
            if (mismatch && !fail_q) begin
                fail_adr_q <= adr2_q;
            end
        end
    end

    // Control, interrupt status and mask
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_q <= 1'b0;
            irq_stat_q <= 2'b00;
            irq_mask_q <= 2'b00;
            irq <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ext_q <= wdata_q[`SDM_CTRL_EXT];
            end
            if (wr_imask) begin
                irq_mask_q <= wdata_q[1:0];
            end
            irq_stat_q <= irq_ev |
                          (irq_stat_q & ~({2{wr_istat}} & wdata_q[1:0]));
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // AXI4-Lite write channel
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SDM_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_have_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[`SDM_AXI_AW-1:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_commit) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `SDM_RESP_OKAY : `SDM_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SDM_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? `SDM_RESP_OKAY : `SDM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

//--- bench/sdm_seq_props.sv
// Port timing checker for sdm_seq.
// Bound from the bench top; top ports only.
`timescale 1ns/1ps
module sdm_seq_props (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Interrupt and memory
    input wire logic        irq,
    input wire logic        mem_ce,
    input wire logic        mem_we
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire both = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && !s_axi_bvalid;
    a_write_resp: assert property (both |-> ##2 s_axi_bvalid)
        else $error("bvalid late");
    a_write_ready: assert property (both |=> !s_axi_awready
        && !s_axi_wready ##1 s_axi_awready && s_axi_wready)
        else $error("ready not back");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_read_done: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready) else $error("read not closed");
    a_reset_state: assert property ($rose(rst_n) |-> s_axi_awready
        && s_axi_wready && s_axi_arready && !s_axi_bvalid
        && !s_axi_rvalid && !irq && !mem_ce)
        else $error("not idle");
    a_write_access: assert property (mem_we |-> mem_ce)
        else $error("stray write");
endmodule

//--- bench/sdm_sram.sv
// SRAM model: bit write enables, one cycle read.
// Counts reads, records the first write.
`timescale 1ns/1ps
module sdm_sram (
    // Memory pins
    input  wire logic        clock,
    input  wire logic        ce,
    input  wire logic        we,
    input  wire logic [7:0]  bwe,
    input  wire logic [6:0]  addr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata,
    // Fault injection and tallies
    input  wire logic        bad,
    output int               rd_cnt,
    output logic             pair,
    output logic      [14:0] fw
);
    logic [7:0] mem [128];
    logic       rd_q;
    logic       got_q;
    initial begin
        {rd_cnt, pair, got_q, rd_q, rdata, fw} = '0;
    end
    always @(posedge clock) begin
        rd_q <= ce && !we;
        if (ce && we) begin
            mem[addr] <= (mem[addr] & ~bwe) | (wdata & bwe);
            if (!got_q) fw <= {addr, wdata};
            got_q <= 1'b1;
        end
        if (ce && !we) begin
            rdata <= mem[addr] ^ {8{bad}};
            rd_cnt <= rd_cnt + 1;
            pair <= pair | rd_q;
        end else
            rdata <= ~rdata; // Idle bus never repeats old data
    end
endmodule

//--- bench/sdm_seq_test.sv
// Testbench for sdm_seq: register tasks and full test runs.
// Assumes sdm_sram as memory and sdm_seq_props bound below.
`timescale 1ns/1ps
`include "sdm_defines.svh"
module sdm_seq_test;
    logic        clock, rst_n, awvalid, wvalid, bready, arvalid, rready, bad;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [1:0]  rs;
    wire         awready, wready, bvalid, arready, rvalid, irq, ce, we, pair;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [7:0]  bwe, mwd, mrd;
    wire  [6:0]  maddr;
    wire  [14:0] fw;
    int          rd_cnt, num_errors, checked, n, m, r0;
    sdm_seq u_dut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq), .mem_ce(ce), .mem_we(we),
        .mem_bwe(bwe), .mem_addr(maddr), .mem_wdata(mwd), .mem_rdata(mrd));
    sdm_sram u_mem (.clock(clock), .ce(ce), .we(we), .bwe(bwe),
        .addr(maddr), .wdata(mwd), .rdata(mrd), .bad(bad),
        .rd_cnt(rd_cnt), .pair(pair), .fw(fw));
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %0t %h %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        num_errors += (n == 100);
        rs = bresp;
    endtask
    task rdr(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        num_errors += (n == 100);
        {rd, rs} = {rdata, rresp};
    endtask
    task run(input logic [31:0] c);
        r0 = rd_cnt;
        wr(`SDM_OFF_CTRL, c);
        repeat (10) @(posedge clock);
        rd = 1;
        for (m = 0; m < 9000 && rd[0]; m++) rdr(`SDM_OFF_STATUS);
        num_errors += rd[0];
    endtask
    task ci(input logic e);
        repeat (3) @(posedge clock);
        chk(irq, e);
    endtask
    task finish_test;
        $display("checked %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        clock = 0;
        forever #10 clock = ~clock;
    end
    initial begin
        #1600000;
        num_errors++;
        finish_test;
    end
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, bad} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rdr(`SDM_OFF_STATUS);
        chk(rd, 32'h80);
        rdr(8'h14);
        chk(rs, `SDM_RESP_SLVERR);
        wr(`SDM_OFF_IRQ_MASK, 3);
        rdr(`SDM_OFF_IRQ_MASK);
        chk(rd, 3);
        $display("test registers done");
        run(1);
        chk(rd_cnt - r0, 4096);
        chk(fw, 15'h0);
        chk(pair, 0);
        rdr(`SDM_OFF_IRQ_STAT);
        chk(rd, 1);
        chk(irq, 1);
        wr(`SDM_OFF_IRQ_STAT, 1);
        ci(0);
        $display("test clean run done");
        bad <= 1'b1;
        run(3);
        chk(rd_cnt - r0, 4105);
        chk(pair, 1);
        rdr(`SDM_OFF_STATUS);
        chk(rd, 32'h86);
        rdr(`SDM_OFF_FAIL_ADR);
        chk(rd, 0);
        wr(`SDM_OFF_IRQ_MASK, 0);
        ci(0);
        wr(`SDM_OFF_IRQ_MASK, 3);
        ci(1);
        wr(`SDM_OFF_IRQ_STAT, 3);
        ci(0);
        $display("test failing run done");
        bad <= 1'b0;
        run(1);
        rdr(`SDM_OFF_STATUS);
        chk(rd, 32'h80);
        $display("test restart done");
        finish_test;
    end
endmodule
bind sdm_seq sdm_seq_props u_props (.clock(clock), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .irq(irq), .mem_ce(mem_ce), .mem_we(mem_we));
